// ---- rtl/arb_if.sv ----
// Request, grant and command lines between the arbiter and one requester
`timescale 1ns/10ps
`default_nettype none
interface arb_if;
   import arb_pkg::*;
   logic dtr_req;
   logic [LEVELS-1:0] level_req;
   logic dtr_grant;
   logic [LEVELS-1:0] level_grant;
   logic bus_busy;
   logic cmd_valid;
   logic [WORD_W-1:0] cmd_vector;

   modport cpu (
      input dtr_req, level_req, bus_busy, cmd_valid, cmd_vector,
      output dtr_grant, level_grant
   );
   modport dev (
      output dtr_req, level_req, bus_busy, cmd_valid, cmd_vector,
      input dtr_grant, level_grant
   );
endinterface
`default_nettype wire

// ---- rtl/arb_pkg.sv ----
// Shared constants for the priority arbiter and the peripheral requester
package arb_pkg;
   localparam int WORD_W = 16;
   localparam int LEVELS = 4;
   localparam logic [2:0] LOWEST_LEVEL = 3'h4;
   localparam int PRI_LSB = 5;
   localparam int PRI_MSB = 7;
   localparam logic [WORD_W-1:0] STACK_STEP = 16'h0002;
   localparam logic [WORD_W-1:0] PSW_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] PC_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] SP_RESET = 16'h0000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int DTR_LIMIT_NS = 3500;
   localparam int ENTRY_TIME_NS = 7200;
   localparam int RTI_TIME_NS = 4500;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] DTR_LIMIT_CYC = CNT_W'(DTR_LIMIT_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ENTRY_CYC = CNT_W'(ENTRY_TIME_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RTI_CYC = CNT_W'(RTI_TIME_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_INT_GNT  = 4'h1,
      ST_PUSH_PSW = 4'h3,
      ST_PUSH_PC  = 4'h2,
      ST_LOAD_PC  = 4'h6,
      ST_LOAD_PSW = 4'h7,
      ST_WAIT_END = 4'h5,
      ST_POP_PC   = 4'h4,
      ST_POP_PSW  = 4'hc,
      ST_DTR      = 4'hd
   } arb_state_type;
endpackage

// ---- rtl/bus_requester.sv ----
// Peripheral end: raises requests, passes grants down the chain, sends vectors
`timescale 1ns/10ps
`default_nettype none
module bus_requester #(
   parameter logic [2:0] LEVEL = 3'h4
) (
   input wire logic i_clock,                          // System clock
   input wire logic i_rst_n,                          // Synchronous reset, active low
   arb_if.dev bus,                                    // Toward the processor
   input wire logic i_dtr_want,                       // Level: wants a direct transfer
   input wire logic i_dtr_done,                       // Pulse: direct transfer finished
   input wire logic i_int_want,                       // Level: wants an interrupt
   input wire logic [arb_pkg::WORD_W-1:0] i_vector,   // Vector address to send
   input wire logic i_chain_dtr_req,                  // Direct request of farther devices
   input wire logic i_chain_int_req,                  // Same-level request of farther devices
   output logic o_chain_dtr_grant,                    // Direct grant passed on
   output logic o_chain_int_grant,                    // Level grant passed on
   output logic o_dtr_owner,                          // Level: this device holds the bus
   output logic o_int_sent                            // Pulse: vector was sent
);
   import arb_pkg::*;

   localparam logic [1:0] LEVEL_IDX = 2'(LEVEL - LOWEST_LEVEL);
   logic dtr_owner_r;
   logic int_busy_r;
   logic sent_r;
   logic [WORD_W-1:0] vector_r;
   logic int_take;

   // requests of any number of farther devices merge into one line
   assign bus.dtr_req = (i_dtr_want & ~dtr_owner_r) | i_chain_dtr_req;
   always_comb begin
      bus.level_req = '0;
      bus.level_req[LEVEL_IDX] = (i_int_want & ~int_busy_r & ~sent_r) | i_chain_int_req;
   end

   // the nearest requester keeps the grant, others see it passed on
   assign o_chain_dtr_grant = bus.dtr_grant & ~i_dtr_want & ~dtr_owner_r;
   assign o_chain_int_grant = bus.level_grant[LEVEL_IDX] & ~i_int_want & ~int_busy_r;
   assign int_take = bus.level_grant[LEVEL_IDX] & i_int_want & ~int_busy_r & ~sent_r;

   // a direct transfer holds the bus until the user says it is done
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         dtr_owner_r <= 1'b0;
      end else if (dtr_owner_r && i_dtr_done) begin
         dtr_owner_r <= 1'b0;
      end else if (bus.dtr_grant && i_dtr_want) begin
         dtr_owner_r <= 1'b1;
      end
   end

   // once on the bus, send the vector for one cycle
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         int_busy_r <= 1'b0;
         vector_r <= '0;
      end else begin
         int_busy_r <= int_take;
         if (int_take) begin
            vector_r <= i_vector;
         end
      end
   end

   // Hides the request while the processor drops its grant
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sent_r <= 1'b0;
      end else begin
         sent_r <= int_busy_r;
      end
   end

   assign bus.bus_busy = dtr_owner_r | int_busy_r;
   assign bus.cmd_valid = int_busy_r;
   assign bus.cmd_vector = vector_r;
   assign o_dtr_owner = dtr_owner_r;
   assign o_int_sent = int_busy_r;
endmodule
`default_nettype wire

// ---- rtl/priority_interrupt_arbiter.sv ----
// Processor end: bus arbitration, interrupt entry and return on the stack
// Notes on behaviour
// - Five request lines; direct transfer ranks highest
// - Direct transfer granted mid-instruction, between bus cycles
// - Level 7 highest, level 4 lowest
// - Priority 0 to 3 lets every level through
// - Interrupt levels granted only at instruction boundaries
// - Priority held in status bits 7 to 5
// - Levels at or below priority are refused
// - Nearest device on a line takes grant
// - Any number of devices per line
// - No release inside read-modify-write
// - Direct requester gets bus within 3.5 us
// - Direct transfer leaves processor state unchanged
// - Grant only when level exceeds priority
// - Granted device sends vector command
// - Save status and counter before service
// - New counter from vector, status from next word
// - First fetch 7.2 us after command
// - Return restores counter and status in 4.5 us
// - Routine interruptible after its first instruction
// - Nested saves never overwrite earlier pairs
// - Register 6 serves as stack pointer
// - Stack pointer steps by two
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_arbiter (
   input wire logic i_clock,                          // System clock
   input wire logic i_rst_n,                          // Synchronous reset, active low
   arb_if.cpu bus,                                    // Toward the requesters
   input wire logic i_bus_cycle_end,                  // Pulse: core bus cycle ended
   input wire logic i_bus_idle,                       // Level: core has no bus cycle open
   input wire logic i_rmw_lock,                       // Level: inside read-modify-write
   input wire logic i_instr_boundary,                 // Pulse: instruction completed
   input wire logic i_rti,                            // Pulse: return from interrupt
   input wire logic i_psw_wr,                         // Pulse: software writes status
   input wire logic [arb_pkg::WORD_W-1:0] i_psw_wdata, // Status write data
   input wire logic i_pc_wr,                          // Pulse: core updates counter
   input wire logic [arb_pkg::WORD_W-1:0] i_pc_wdata, // Counter write data
   input wire logic i_sp_wr,                          // Pulse: core updates register 6
   input wire logic [arb_pkg::WORD_W-1:0] i_sp_wdata, // Register 6 write data
   input wire logic i_mem_ack,                        // Pulse: memory word done
   input wire logic [arb_pkg::WORD_W-1:0] i_mem_rdata, // Memory read data
   output logic o_mem_req,                            // Level: memory access open
   output logic o_mem_we,                             // Write when high
   output logic [arb_pkg::WORD_W-1:0] o_mem_addr,     // Word address
   output logic [arb_pkg::WORD_W-1:0] o_mem_wdata,    // Write data
   output logic o_core_hold,                          // Level: core must stall
   output logic o_fetch,                              // Pulse: fetch at o_pc now
   output logic [arb_pkg::WORD_W-1:0] o_pc,           // Program counter
   output logic [arb_pkg::WORD_W-1:0] o_psw,          // Processor status word
   output logic [arb_pkg::WORD_W-1:0] o_sp            // Hardware stack pointer
);
   import arb_pkg::*;

   arb_state_type state_r, state_nxt, ret_r;
   logic [WORD_W-1:0] pc_r, psw_r, sp_r, vec_r, mem_addr_r, mem_wdata_r;
   logic mem_req_r, mem_we_r, fetch_r, first_done_r, dtr_grant_r, rti_mode_r;
   logic [LEVELS-1:0] level_grant_r;
   logic [CNT_W-1:0] cnt_r;
   logic [2:0] pri;
   logic [2:0] top_level;
   logic top_valid, dtr_slot, int_ok, step_free, mem_done, dtr_enter;

   assign pri = psw_r[PRI_MSB:PRI_LSB];

   // pick the highest pending level, 7 down to 4
   always_comb begin
      top_level = LOWEST_LEVEL;
      top_valid = 1'b0;
      for (int i = 0; i < LEVELS; i++) begin
         if (bus.level_req[i]) begin
            top_level = LOWEST_LEVEL + 3'(i);
            top_valid = 1'b1;
         end
      end
   end

   // same or lower levels are refused; follows since 4 exceeds 0 to 3
   // only at a boundary, and only once a routine ran one instruction
   assign int_ok = top_valid && (top_level > pri) && i_instr_boundary && first_done_r;
   // never release between the read and write halves
   assign dtr_slot = (i_bus_cycle_end | i_bus_idle) & ~i_rmw_lock;
   // Own stack words are bus cycles too, so a transfer may slip between them
   assign step_free = ~mem_req_r & ~fetch_r;
   assign mem_done = mem_req_r & i_mem_ack;
   assign dtr_enter = bus.dtr_req && !dtr_grant_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            // direct transfers win over every interrupt level
            // taken between bus cycles, not at instruction end
            if (dtr_enter && dtr_slot) begin
               state_nxt = ST_DTR;
            end else if (i_rti) begin
               state_nxt = ST_POP_PC;
            end else if (int_ok) begin
               state_nxt = ST_INT_GNT;
            end
         end
         ST_DTR: begin
            // The grant is already down once the device took the bus, so only busy and
            // request decide when the core may resume
            if (!bus.bus_busy && !bus.dtr_req) begin
               state_nxt = ret_r;
            end
         end
         ST_INT_GNT: begin
            if (bus.cmd_valid) begin
               state_nxt = ST_PUSH_PSW;
            end else if (bus.level_req == '0) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_PUSH_PSW: state_nxt = mem_done ? ST_PUSH_PC : state_r;
         ST_PUSH_PC: state_nxt = mem_done ? ST_LOAD_PC : state_r;
         ST_LOAD_PC: state_nxt = mem_done ? ST_LOAD_PSW : state_r;
         ST_LOAD_PSW: state_nxt = mem_done ? ST_WAIT_END : state_r;
         ST_POP_PC: state_nxt = mem_done ? ST_POP_PSW : state_r;
         ST_POP_PSW: state_nxt = mem_done ? ST_WAIT_END : state_r;
         ST_WAIT_END: state_nxt = fetch_r ? ST_IDLE : state_r;
         default: state_nxt = ST_IDLE;
      endcase
      if (state_r != ST_IDLE && state_r != ST_DTR && state_r != ST_INT_GNT
          && step_free && dtr_enter) begin
         state_nxt = ST_DTR;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state_r <= ST_IDLE;
         ret_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
         if (state_nxt == ST_DTR && state_r != ST_DTR) begin
            ret_r <= state_r;
         end
      end
   end

   // the grant is raised two cycles after a free slot, well inside the limit
   // nothing of pc, status or pointer moves while another master holds the bus
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         dtr_grant_r <= 1'b0;
      end else if (state_r == ST_DTR && !bus.bus_busy && dtr_grant_r && !bus.dtr_req) begin
         dtr_grant_r <= 1'b0;
      end else if (state_r == ST_DTR && bus.bus_busy) begin
         dtr_grant_r <= 1'b0;
      end else if (state_r == ST_DTR && !bus.bus_busy) begin
         dtr_grant_r <= bus.dtr_req;
      end
   end

   // the grant line of the winning level stays up until the command, or until every level request drops
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         level_grant_r <= '0;
      end else if (state_r == ST_IDLE && state_nxt == ST_INT_GNT) begin
         level_grant_r <= LEVELS'(1) << 2'(top_level - LOWEST_LEVEL);
      end else if (state_r == ST_INT_GNT && state_nxt != ST_INT_GNT) begin
         level_grant_r <= '0;
      end
   end

   // latch the vector carried by the device command
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         vec_r <= '0;
      end else if (state_r == ST_INT_GNT && bus.cmd_valid) begin
         vec_r <= bus.cmd_vector;
      end
   end

   // Memory word requests; each stack step issues once and waits for its ack
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         mem_req_r <= 1'b0;
         mem_we_r <= 1'b0;
         mem_addr_r <= '0;
         mem_wdata_r <= '0;
      end else if (mem_done) begin
         mem_req_r <= 1'b0;
      end else if (!mem_req_r && state_nxt == state_r && !fetch_r) begin
         case (state_r)
            // status first, each at a pre-decremented slot
            ST_PUSH_PSW: begin
               mem_req_r <= 1'b1;
               mem_we_r <= 1'b1;
               mem_addr_r <= sp_r - STACK_STEP;
               mem_wdata_r <= psw_r;
            end
            ST_PUSH_PC: begin
               mem_req_r <= 1'b1;
               mem_we_r <= 1'b1;
               mem_addr_r <= sp_r - STACK_STEP;
               mem_wdata_r <= pc_r;
            end
            // counter from the vector, status from the next word
            ST_LOAD_PC: begin
               mem_req_r <= 1'b1;
               mem_we_r <= 1'b0;
               mem_addr_r <= vec_r;
            end
            ST_LOAD_PSW: begin
               mem_req_r <= 1'b1;
               mem_we_r <= 1'b0;
               mem_addr_r <= vec_r + STACK_STEP;
            end
            ST_POP_PC, ST_POP_PSW: begin
               mem_req_r <= 1'b1;
               mem_we_r <= 1'b0;
               mem_addr_r <= sp_r;
            end
            default: mem_req_r <= 1'b0;
         endcase
      end
   end

   // register 6 is the implicit pointer; always steps of two
   // each push goes below the last, so nested pairs survive
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sp_r <= SP_RESET;
      end else if (mem_done && (state_r == ST_PUSH_PSW || state_r == ST_PUSH_PC)) begin
         sp_r <= sp_r - STACK_STEP;
      end else if (mem_done && (state_r == ST_POP_PC || state_r == ST_POP_PSW)) begin
         sp_r <= sp_r + STACK_STEP;
      end else if (i_sp_wr && state_r == ST_IDLE) begin
         sp_r <= i_sp_wdata;
      end
   end

   // counter reloads from vector or stack
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         pc_r <= PC_RESET;
      end else if (mem_done && (state_r == ST_LOAD_PC || state_r == ST_POP_PC)) begin
         pc_r <= i_mem_rdata;
      end else if (i_pc_wr && state_r == ST_IDLE) begin
         pc_r <= i_pc_wdata;
      end
   end

   // software sets the priority through the status word
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         psw_r <= PSW_RESET;
      end else if (mem_done && (state_r == ST_LOAD_PSW || state_r == ST_POP_PSW)) begin
         psw_r <= i_mem_rdata;
      end else if (i_psw_wr && state_r == ST_IDLE) begin
         psw_r <= i_psw_wdata;
      end
   end

   // time from command or return, fetch once the figure is reached
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         cnt_r <= '0;
         rti_mode_r <= 1'b0;
         fetch_r <= 1'b0;
      end else begin
         fetch_r <= 1'b0;
         if (state_nxt == ST_PUSH_PSW && state_r == ST_INT_GNT) begin
            cnt_r <= CNT_ONE;
            rti_mode_r <= 1'b0;
         end else if (state_nxt == ST_POP_PC && state_r == ST_IDLE) begin
            cnt_r <= CNT_ONE;
            rti_mode_r <= 1'b1;
         end else if (state_r == ST_WAIT_END && !fetch_r
                      && cnt_r >= (rti_mode_r ? RTI_CYC : ENTRY_CYC) - CNT_ONE) begin
            fetch_r <= 1'b1;
         end else if (cnt_r != '1) begin
            cnt_r <= cnt_r + CNT_ONE;
         end
      end
   end

   // a new routine must finish one instruction before nesting
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         first_done_r <= 1'b1;
      end else if (fetch_r && !rti_mode_r) begin
         first_done_r <= 1'b0;
      end else if (i_instr_boundary && state_r == ST_IDLE) begin
         first_done_r <= 1'b1;
      end
   end

   assign bus.dtr_grant = dtr_grant_r;
   assign bus.level_grant = level_grant_r;
   assign o_mem_req = mem_req_r;
   assign o_mem_we = mem_we_r;
   assign o_mem_addr = mem_addr_r;
   assign o_mem_wdata = mem_wdata_r;
   assign o_core_hold = (state_r != ST_IDLE) | (dtr_enter & dtr_slot);
   assign o_fetch = fetch_r;
   assign o_pc = pc_r;
   assign o_psw = psw_r;
   assign o_sp = sp_r;
endmodule
`default_nettype wire

// ---- tb/priority_interrupt_arbiter_monitor.sv ----
// Concurrent checks on the request, grant and command lines
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_arbiter_monitor (
   input wire logic i_clock,                          // System clock
   input wire logic i_rst_n,                          // Synchronous reset, active low
   input wire logic dtr_req,                          // Direct transfer request
   input wire logic [arb_pkg::LEVELS-1:0] level_req,  // Level requests
   input wire logic dtr_grant,                        // Direct transfer grant
   input wire logic [arb_pkg::LEVELS-1:0] level_grant, // Level grant
   input wire logic bus_busy,                         // Device holds the bus
   input wire logic cmd_valid                         // Vector command pulse
);
   import arb_pkg::*;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   // Highest pending level as a one-hot word
   function automatic logic [LEVELS-1:0] top_level(input logic [LEVELS-1:0] r);
      top_level = '0;
      for (int i = 0; i < LEVELS; i++) begin
         if (r[i]) begin
            top_level = '0;
            top_level[i] = 1'b1;
         end
      end
   endfunction

   a_grant_one_hot: assert property ($onehot0(level_grant))
      else $error("level grant not one-hot");
   a_grant_highest: assert property (
      $rose(|level_grant) |-> level_grant == top_level($past(level_req)))
      else $error("grant not on highest pending level");
   a_direct_excludes: assert property (!(dtr_grant && |level_grant))
      else $error("direct and level grant together");
   a_cmd_after_grant: assert property (
      cmd_valid |-> $past(|level_grant) && bus_busy)
      else $error("command without grant or bus");
   a_grant_ends: assert property (cmd_valid |=> level_grant == '0)
      else $error("level grant kept after command");
   a_direct_cause: assert property ($rose(dtr_grant) |-> $past(dtr_req, 2))
      else $error("direct grant without request");
   a_direct_release: assert property (dtr_grant && bus_busy |=> !dtr_grant)
      else $error("direct grant kept after bus taken");
   a_direct_latency: assert property ($rose(dtr_req) |-> ##[2:437] dtr_grant)
      else $error("direct grant too late");
endmodule
`default_nettype wire

// ---- tb/priority_interrupt_arbiter_test.sv ----
// Bench joining the arbiter and one requester, with memory and core stimulus
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      miscompares++; \
      $display("[FAIL] %s expected %0h seen %0h", n, e, g); \
   end \
end
module priority_interrupt_arbiter_test;
   import arb_pkg::*;
   localparam logic [2:0] DEV_LEVEL = 3'h5;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_bus_cycle_end = 1'b0, i_bus_idle = 1'b1, i_rmw_lock = 1'b0, i_instr_boundary = 1'b0;
   logic i_rti = 1'b0, i_psw_wr = 1'b0, i_pc_wr = 1'b0, i_sp_wr = 1'b0, i_mem_ack = 1'b0;
   logic i_dtr_want = 1'b0, i_dtr_done = 1'b0, i_int_want = 1'b0;
   logic i_chain_dtr_req = 1'b0, i_chain_int_req = 1'b0;
   logic [WORD_W-1:0] i_psw_wdata = 16'h0000, i_pc_wdata = 16'h0000, i_sp_wdata = 16'h0000;
   logic [WORD_W-1:0] i_mem_rdata = 16'h0000, i_vector = 16'h0000;
   logic o_mem_req, o_mem_we, o_core_hold, o_fetch, o_chain_dtr_grant, o_chain_int_grant;
   logic o_dtr_owner, o_int_sent;
   logic [WORD_W-1:0] o_mem_addr, o_mem_wdata, o_pc, o_psw, o_sp;
   logic [WORD_W-1:0] mem [0:(2**WORD_W)-1];
   logic [WORD_W:0] log_q [$];
   logic [WORD_W-1:0] s, ps0, pc0, v, np, nps, d;
   logic [3*WORD_W-1:0] snap;
   int seed = 40, miscompares = 0, cmp_count = 0, cg = 0, og = 0;
   int t, c0;
   bit got;
   wire logic [4:0] watch = {o_chain_dtr_grant, o_chain_int_grant, o_dtr_owner, o_fetch, o_int_sent};

   arb_if link ();
   priority_interrupt_arbiter priority_interrupt_arbiter_inst (
      .i_clock, .i_rst_n, .bus(link), .i_bus_cycle_end, .i_bus_idle, .i_rmw_lock,
      .i_instr_boundary, .i_rti, .i_psw_wr, .i_psw_wdata, .i_pc_wr, .i_pc_wdata, .i_sp_wr,
      .i_sp_wdata, .i_mem_ack, .i_mem_rdata, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata,
      .o_core_hold, .o_fetch, .o_pc, .o_psw, .o_sp
   );
   bus_requester #(.LEVEL(DEV_LEVEL)) bus_requester_inst (
      .i_clock, .i_rst_n, .bus(link), .i_dtr_want, .i_dtr_done, .i_int_want, .i_vector,
      .i_chain_dtr_req, .i_chain_int_req, .o_chain_dtr_grant, .o_chain_int_grant, .o_dtr_owner,
      .o_int_sent
   );
   priority_interrupt_arbiter_monitor priority_interrupt_arbiter_monitor_inst (
      .i_clock, .i_rst_n, .dtr_req(link.dtr_req), .level_req(link.level_req),
      .dtr_grant(link.dtr_grant), .level_grant(link.level_grant), .bus_busy(link.bus_busy),
      .cmd_valid(link.cmd_valid)
   );

   always #(CLK_PERIOD_NS / 2) i_clock = ~i_clock;

   // Random stalls on memory; the slot toggles so direct requests see a gap every other cycle
   always @(negedge i_clock) begin
      i_bus_cycle_end <= ~i_bus_cycle_end;
      if (i_mem_ack) begin
         i_mem_ack <= 1'b0;
      end else if (o_mem_req && ($random(seed) & 1)) begin
         i_mem_ack <= 1'b1;
         i_mem_rdata <= mem[o_mem_addr];
         if (o_mem_we) mem[o_mem_addr] = o_mem_wdata;
         log_q.push_back({o_mem_we, o_mem_addr});
      end
   end

   // Sampled before the edge updates land, so counts never race the scenarios
   always @(posedge i_clock) begin
      if (o_chain_int_grant === 1'b1) cg++;
      if (o_dtr_owner === 1'b1) og++;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge i_clock);
   endtask

   task automatic wait_hi(input int w, input int lim, output int n);
      n = 0;
      while (watch[w] !== 1'b1 && n < lim) begin
         cyc(1);
         n++;
      end
   endtask

   task automatic boundary();
      i_instr_boundary = 1'b1;
      cyc(1);
      i_instr_boundary = 1'b0;
   endtask

   task automatic set_regs(input logic [WORD_W-1:0] ps, pc, sp);
      {i_psw_wdata, i_pc_wdata, i_sp_wdata} = {ps, pc, sp};
      {i_psw_wr, i_pc_wr, i_sp_wr} = 3'h7;
      cyc(1);
      {i_psw_wr, i_pc_wr, i_sp_wr} = 3'h0;
      cyc(1);
   endtask

   // Two boundaries: the first may only finish a routine's first instruction
   task automatic enter(output bit ok, output int n);
      ok = 1'b0;
      n = 0;
      i_int_want = 1'b1;
      for (int k = 0; k < 2 && !ok; k++) begin
         boundary();
         wait_hi(0, 6, n);
         ok = (n < 6);
      end
      i_int_want = 1'b0;
      // One more cycle lets the arbiter settle back to idle after the fetch
      if (ok) begin
         wait_hi(1, 1200, n);
         cyc(1);
      end
   endtask

   task automatic ret(output int n);
      i_rti = 1'b1;
      cyc(1);
      i_rti = 1'b0;
      wait_hi(1, 800, n);
      cyc(1);
   endtask

   function automatic logic [WORD_W:0] exp_acc(input int k, input logic [WORD_W-1:0] sp, vec);
      case (k)
         0: exp_acc = {1'b1, sp - STACK_STEP};
         1: exp_acc = {1'b1, sp - STACK_STEP - STACK_STEP};
         2: exp_acc = {1'b0, vec};
         default: exp_acc = {1'b0, vec + STACK_STEP};
      endcase
   endfunction

   function automatic bit exp_grant(input int p);
      exp_grant = 3'(p) < DEV_LEVEL;
   endfunction

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #(40000 * CLK_PERIOD_NS);
      miscompares++;
      results();
   end

   initial begin
      d = STACK_STEP;
      cyc(2);
      i_rst_n = 1'b1;
      cyc(1);
      `CHK("reset", {PC_RESET, PSW_RESET, SP_RESET, 5'h00}, {o_pc, o_psw, o_sp, link.level_grant, link.dtr_grant})
      s = 16'h4000 | (16'($random(seed)) & 16'h0ffe);
      pc0 = 16'($random(seed)) & 16'hfffe;
      ps0 = 16'($random(seed)) & 16'hff1f;
      v = 16'h0040 | (16'($random(seed)) & 16'h003c);
      np = 16'($random(seed)) & 16'hfffe;
      nps = 16'h0080 | (16'($random(seed)) & 16'hff1f);
      mem[v] = np;
      mem[v + d] = nps;
      i_vector = v;
      set_regs(ps0, pc0, s);
      i_int_want = 1'b1;
      wait_hi(0, 20, t);
      `CHK("no grant off boundary", 20, t)
      log_q.delete();
      enter(got, t);
      `CHK("entry grant", 1'b1, got)
      `CHK("entry time", 1'b1, t >= 898 && t <= 902)
      for (int k = 0; k < 4; k++) `CHK("stack access", exp_acc(k, s, v), log_q[k])
      `CHK("saved words", {ps0, pc0}, {mem[s - d], mem[s - 2 * d]})
      `CHK("new pc psw sp", {np, nps, 16'(s - 2 * d)}, {o_pc, o_psw, o_sp})
      i_int_want = 1'b1;
      boundary();
      wait_hi(0, 6, t);
      `CHK("no nesting before first instruction", 6, t)
      enter(got, t);
      `CHK("nested entry", 1'b1, got)
      `CHK("nested saves", {ps0, pc0, nps, np}, {mem[s - d], mem[s - 2 * d], mem[s - 3 * d], mem[s - 4 * d]})
      ret(t);
      `CHK("return time", 1'b1, t >= 559 && t <= 565)
      `CHK("first return", {np, nps, 16'(s - 2 * d)}, {o_pc, o_psw, o_sp})
      ret(t);
      `CHK("second return", {pc0, ps0, s}, {o_pc, o_psw, o_sp})
      for (int p = 0; p < 8; p++) begin
         set_regs({o_psw[15:8], 3'(p), o_psw[4:0]}, o_pc, o_sp);
         `CHK("priority field", 3'(p), o_psw[PRI_MSB:PRI_LSB])
         enter(got, t);
         `CHK("grant versus priority", exp_grant(p), got)
      end
      set_regs(PSW_RESET, o_pc, o_sp);
      i_chain_int_req = 1'b1;
      boundary();
      cyc(1);
      boundary();
      wait_hi(3, 6, t);
      `CHK("far device granted", 1'b1, t < 6)
      i_chain_int_req = 1'b0;
      cyc(3);
      `CHK("grant withdrawn", 5'h00, {o_chain_int_grant, link.level_grant})
      i_chain_int_req = 1'b1;
      c0 = cg;
      enter(got, t);
      i_chain_int_req = 1'b0;
      `CHK("near device wins", {1'b1, c0}, {got, cg})
      snap = {o_pc, o_psw, o_sp};
      {i_bus_idle, i_rmw_lock, i_dtr_want, i_chain_dtr_req} = 4'h7;
      c0 = og;
      cyc(30);
      `CHK("held off in locked pair", c0, og)
      i_rmw_lock = 1'b0;
      wait_hi(2, 437, t);
      `CHK("direct bus in time", 1'b1, t < 437)
      `CHK("core held, far blocked", 2'h2, {o_core_hold, o_chain_dtr_grant})
      cyc(5);
      {i_dtr_done, i_dtr_want, i_chain_dtr_req} = 3'h4;
      cyc(1);
      i_dtr_done = 1'b0;
      cyc(4);
      `CHK("state kept", snap, {o_pc, o_psw, o_sp})
      `CHK("core resumes", 1'b0, o_core_hold)
      i_chain_dtr_req = 1'b1;
      wait_hi(4, 437, t);
      `CHK("far direct granted", 1'b1, t < 437)
      i_chain_dtr_req = 1'b0;
      i_bus_idle = 1'b1;
      cyc(6);
      `CHK("bus returned", 1'b0, o_core_hold)
      results();
   end
endmodule
`default_nettype wire
